// >>> src/ssa_pkg.sv
// constants and types shared by the sequence set advance controller
package ssa_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TOTAL = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    // control register field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SRC_LSB = 1;
    localparam int CTRL_RSRC_LSB = 3;
    localparam int CTRL_INV1_BIT = 5;
    localparam int CTRL_INV2_BIT = 6;
    // status register field positions
    localparam int STAT_IDX_LSB = 0;
    localparam int STAT_ACT_BIT = 8;
    localparam int STAT_WAIT_BIT = 9;
    localparam int STAT_EN_BIT = 10;
    localparam int STAT_DROP_LSB = 16;
    // set count limits and reset values
    localparam int MAX_SETS = 64;
    localparam logic [6:0] TOTAL_MAX = 7'h40;
    localparam logic [6:0] TOTAL_RST = 7'h40;
    localparam logic [5:0] IDX_RST = 6'h00;
    localparam logic [7:0] DROP_RST = 8'h00;
    // settling time after a line changes, in ns and in clock cycles
    localparam int CLK_NS = 20;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    // advance source selection
    typedef enum logic [1:0] {
        SRC_ALWAYS = 2'h0,
        SRC_LINE1 = 2'h1,
        SRC_LINE2 = 2'h2,
        SRC_OFF = 2'h3
    } ssa_src_t;
    // restart source selection
    typedef enum logic [1:0] {
        RSRC_NONE = 2'h0,
        RSRC_LINE1 = 2'h1,
        RSRC_LINE2 = 2'h2,
        RSRC_RSVD = 2'h3
    } ssa_rsrc_t;
    // sequencer states, gray coded along off -> load -> run
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_LOAD0 = 2'b01,
        ST_RUN = 2'b11
    } ssa_state_t;
endpackage : ssa_pkg

// >>> src/ssa_line_if.sv
// conditioned input line between line conditioner and controller
`timescale 1ns/1ps
interface ssa_line_if;
    logic level;
    logic busy;
    logic invert;
    modport cond (output level, output busy, input invert);
    modport ctrl (input level, input busy, output invert);
endinterface : ssa_line_if

// >>> src/ssa_line_cond.sv
// input line synchroniser with invert and change settling window
`timescale 1ns/1ps
module ssa_line_cond #(
    parameter int SETTLE_CYC = ssa_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw pin
    input wire logic line_in,
    // conditioned line to the controller
    ssa_line_if.cond lif
);
    localparam int CW = $clog2(SETTLE_CYC + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(SETTLE_CYC);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic busy;
        logic [CW-1:0] cnt;
    } ssa_cond_t;

    ssa_cond_t r_reg;
    ssa_cond_t r_next;

    // synchronise, invert, and hold busy while the line settles
    always_comb begin
        r_next = r_reg;
        r_next.s1 = line_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.level = r_reg.s2 ^ lif.invert;
        if (r_reg.s2 != r_reg.s3) begin
            r_next.cnt = CNT_LOAD;
            r_next.busy = 1'b1;
        end else if (r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - CW'(1);
            r_next.busy = 1'b1;
        end else begin
            r_next.busy = 1'b0;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign lif.level = r_reg.level;
    assign lif.busy = r_reg.busy;
endmodule : ssa_line_cond

// >>> src/ssa_ctrl.sv
// sequence set advance controller with apb registers
`timescale 1ns/1ps
module ssa_ctrl #(
    parameter int SETTLE_CYC = ssa_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins from the trigger source and line drivers
    input wire logic frame_trig,
    input wire logic line1,
    input wire logic line2,
    // acquisition engine side
    output logic [5:0] set_index,
    output logic set_active,
    output logic set_load,
    output logic acq_start,
    output logic [5:0] acq_set,
    output logic trig_waiting
);
    typedef struct packed {
        ssa_pkg::ssa_state_t st;
        logic en;
        ssa_pkg::ssa_src_t src;
        ssa_pkg::ssa_rsrc_t rsrc;
        logic inv1;
        logic inv2;
        logic [6:0] total;
        logic [5:0] idx;
        logic active;
        logic load_p;
        logic acq_p;
        logic [5:0] acq_set;
        logic wait_o;
        logic [7:0] drop_cnt;
        logic [2:0] trg;
        logic step_req;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ssa_ctrl_t;

    ssa_ctrl_t r_reg;
    ssa_ctrl_t r_next;
    logic trig_rise;
    logic trig_acc;
    logic line_quiet;
    logic rst_hit;
    logic adv_hit;
    logic adv_level;

    ssa_line_if l1_if();
    ssa_line_if l2_if();

    // line conditioners for both input lines
    ssa_line_cond #(.SETTLE_CYC(SETTLE_CYC)) u_line1 (
        .pclk(pclk),
        .presetn(presetn),
        .line_in(line1),
        .lif(l1_if.cond)
    );
    ssa_line_cond #(.SETTLE_CYC(SETTLE_CYC)) u_line2 (
        .pclk(pclk),
        .presetn(presetn),
        .line_in(line2),
        .lif(l2_if.cond)
    );

    // per-line invert options from the control register
    assign l1_if.invert = r_reg.inv1;
    assign l2_if.invert = r_reg.inv2;

    // next set index with wrap at the end of the cycle
    function automatic logic [5:0] next_idx(input logic [5:0] cur, input logic [6:0] total);
        logic [6:0] last;
        last = total - 7'h01;
        if ({1'b0, cur} >= last) begin
            next_idx = 6'h00;
        end else begin
            next_idx = cur + 6'h01;
        end
    endfunction : next_idx

    // clamp a written set count into the legal range
    function automatic logic [6:0] clamp_total(input logic [31:0] v);
        if (v == 32'h0000_0000) begin
            clamp_total = 7'h01;
        end else if (v > 32'(ssa_pkg::MAX_SETS)) begin
            clamp_total = ssa_pkg::TOTAL_MAX;
        end else begin
            clamp_total = v[6:0];
        end
    endfunction : clamp_total

    // trigger edge, acceptance and source decisions
    assign trig_rise = r_reg.trg[1] & ~r_reg.trg[2];
    // a line change already seen in the synchroniser blocks the trigger before the status drops
    assign line_quiet = r_reg.wait_o & ~(l1_if.busy | l2_if.busy);
    assign trig_acc = trig_rise & line_quiet;
    assign rst_hit = ((r_reg.rsrc == ssa_pkg::RSRC_LINE1) & l1_if.level) |
                     ((r_reg.rsrc == ssa_pkg::RSRC_LINE2) & l2_if.level);
    assign adv_level = (r_reg.src == ssa_pkg::SRC_LINE1) ? l1_if.level : l2_if.level;
    assign adv_hit = (r_reg.src == ssa_pkg::SRC_ALWAYS) |
                     (((r_reg.src == ssa_pkg::SRC_LINE1) | (r_reg.src == ssa_pkg::SRC_LINE2)) & adv_level);

    // sequencer state machine and register access
    always_comb begin
        r_next = r_reg;
        r_next.load_p = 1'b0;
        r_next.acq_p = 1'b0;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        r_next.trg = {r_reg.trg[1:0], frame_trig};
        r_next.wait_o = ~(l1_if.busy | l2_if.busy);
        if (trig_rise & ~line_quiet & (r_reg.drop_cnt != 8'hFF)) begin
            r_next.drop_cnt = r_reg.drop_cnt + 8'h01;
        end
        if (trig_acc) begin
            r_next.acq_p = 1'b1;
            r_next.acq_set = r_reg.idx;
        end
        case (r_reg.st)
            ssa_pkg::ST_OFF: begin
                r_next.active = 1'b0;
                r_next.step_req = 1'b0;
                if (r_reg.en) begin
                    r_next.st = ssa_pkg::ST_LOAD0;
                end
            end
            ssa_pkg::ST_LOAD0: begin
                r_next.idx = ssa_pkg::IDX_RST;
                r_next.active = 1'b1;
                r_next.load_p = 1'b1;
                r_next.st = ssa_pkg::ST_RUN;
                r_next.acq_set = ssa_pkg::IDX_RST;
            end
            ssa_pkg::ST_RUN: begin
                if (!r_reg.en) begin
                    r_next.st = ssa_pkg::ST_OFF;
                    r_next.active = 1'b0;
                    r_next.load_p = 1'b1;
                    r_next.step_req = 1'b0;
                end else if (trig_acc & rst_hit) begin
                    r_next.idx = ssa_pkg::IDX_RST;
                    r_next.acq_set = ssa_pkg::IDX_RST;
                    r_next.load_p = 1'b1;
                end else if (trig_acc & adv_hit) begin
                    r_next.idx = next_idx(r_reg.idx, r_reg.total);
                    r_next.acq_set = next_idx(r_reg.idx, r_reg.total);
                    r_next.load_p = 1'b1;
                end else if (!trig_acc & r_reg.step_req) begin
                    r_next.step_req = 1'b0;
                    if (r_reg.src == ssa_pkg::SRC_OFF) begin
                        r_next.idx = next_idx(r_reg.idx, r_reg.total);
                        r_next.load_p = 1'b1;
                    end
                end
            end
            default: begin
                r_next.st = ssa_pkg::ST_OFF;
                r_next.active = 1'b0;
            end
        endcase
        // apb access phase, answered one cycle after it begins
        if (psel & penable & ~r_reg.pready) begin
            r_next.pready = 1'b1;
            r_next.prdata = 32'h0000_0000;
            case (paddr)
                ssa_pkg::OFS_CTRL: begin
                    if (pwrite) begin
                        r_next.en = pwdata[ssa_pkg::CTRL_EN_BIT];
                        r_next.src = ssa_pkg::ssa_src_t'(pwdata[ssa_pkg::CTRL_SRC_LSB +: 2]);
                        r_next.rsrc = ssa_pkg::ssa_rsrc_t'(pwdata[ssa_pkg::CTRL_RSRC_LSB +: 2]);
                        r_next.inv1 = pwdata[ssa_pkg::CTRL_INV1_BIT];
                        r_next.inv2 = pwdata[ssa_pkg::CTRL_INV2_BIT];
                    end else begin
                        r_next.prdata[ssa_pkg::CTRL_EN_BIT] = r_reg.en;
                        r_next.prdata[ssa_pkg::CTRL_SRC_LSB +: 2] = r_reg.src;
                        r_next.prdata[ssa_pkg::CTRL_RSRC_LSB +: 2] = r_reg.rsrc;
                        r_next.prdata[ssa_pkg::CTRL_INV1_BIT] = r_reg.inv1;
                        r_next.prdata[ssa_pkg::CTRL_INV2_BIT] = r_reg.inv2;
                    end
                end
                ssa_pkg::OFS_TOTAL: begin
                    if (pwrite) begin
                        r_next.total = clamp_total(pwdata);
                    end else begin
                        r_next.prdata[6:0] = r_reg.total;
                    end
                end
                ssa_pkg::OFS_CMD: begin
                    if (pwrite & pwdata[0]) begin
                        r_next.step_req = 1'b1; // software_step_command, set wins
                    end
                end
                ssa_pkg::OFS_STATUS: begin
                    if (!pwrite) begin
                        r_next.prdata[ssa_pkg::STAT_IDX_LSB +: 6] = r_reg.idx;
                        r_next.prdata[ssa_pkg::STAT_ACT_BIT] = r_reg.active;
                        r_next.prdata[ssa_pkg::STAT_WAIT_BIT] = r_reg.wait_o;
                        r_next.prdata[ssa_pkg::STAT_EN_BIT] = (r_reg.st != ssa_pkg::ST_OFF);
                        r_next.prdata[ssa_pkg::STAT_DROP_LSB +: 8] = r_reg.drop_cnt;
                    end
                end
                default: begin
                    r_next.pslverr = 1'b1; // unmapped address
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.st <= ssa_pkg::ST_OFF;
            r_reg.src <= ssa_pkg::SRC_ALWAYS;
            r_reg.rsrc <= ssa_pkg::RSRC_NONE;
            r_reg.total <= ssa_pkg::TOTAL_RST;
            r_reg.idx <= ssa_pkg::IDX_RST;
            r_reg.drop_cnt <= ssa_pkg::DROP_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register
    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign set_index = r_reg.idx;
    assign set_active = r_reg.active;
    assign set_load = r_reg.load_p;
    assign acq_start = r_reg.acq_p;
    assign acq_set = r_reg.acq_set;
    assign trig_waiting = r_reg.wait_o;

    // checks on the sequencing behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_enable;
        (r_reg.st == ssa_pkg::ST_OFF) && r_reg.en ##1 (r_reg.st == ssa_pkg::ST_LOAD0);
    endsequence

    sequence s_first_adv;
        (r_reg.st == ssa_pkg::ST_RUN) && (r_reg.idx == 6'h00) && r_reg.en && trig_acc && !rst_hit &&
            (r_reg.src == ssa_pkg::SRC_ALWAYS) && (r_reg.total > 7'h01);
    endsequence

    a_enable_load_zero: assert property (s_enable |=> set_load && set_active && (set_index == 6'h00))
        else $error("enable did not load set 0");
    a_first_set_one: assert property (s_first_adv |=> acq_start && (acq_set == 6'h01) && (set_index == 6'h01))
        else $error("first always-active acquisition did not use set 1");
    a_restart_wins: assert property ((r_reg.st == ssa_pkg::ST_RUN) && r_reg.en && trig_acc && rst_hit
        |=> (set_index == 6'h00) && (acq_set == 6'h00) && set_load)
        else $error("restart did not select set 0");
    a_always_step: assert property ((r_reg.st == ssa_pkg::ST_RUN) && r_reg.en && trig_acc && !rst_hit &&
        (r_reg.src == ssa_pkg::SRC_ALWAYS) && ({1'b0, r_reg.idx} < r_reg.total - 7'h01)
        |=> (set_index == $past(r_reg.idx) + 6'h01))
        else $error("always-active trigger did not step");
    a_wrap_zero: assert property ((r_reg.st == ssa_pkg::ST_RUN) && r_reg.en && trig_acc && adv_hit &&
        ({1'b0, r_reg.idx} == r_reg.total - 7'h01) |=> (set_index == 6'h00))
        else $error("advance past last set did not wrap");
    a_line_low_hold: assert property ((r_reg.st == ssa_pkg::ST_RUN) && r_reg.en && trig_acc && !rst_hit &&
        ((r_reg.src == ssa_pkg::SRC_LINE1) || (r_reg.src == ssa_pkg::SRC_LINE2)) && !adv_level
        |=> $stable(set_index) && !set_load && (acq_set == set_index))
        else $error("low advance line changed the set");
    a_line_high_step: assert property ((r_reg.st == ssa_pkg::ST_RUN) && r_reg.en && trig_acc && !rst_hit &&
        ((r_reg.src == ssa_pkg::SRC_LINE1) || (r_reg.src == ssa_pkg::SRC_LINE2)) && adv_level
        |=> set_load && (set_index == acq_set))
        else $error("high advance line did not load the next set");
    a_off_no_trig: assert property ((r_reg.st == ssa_pkg::ST_RUN) && r_reg.en && trig_acc && !rst_hit &&
        (r_reg.src == ssa_pkg::SRC_OFF) |=> $stable(set_index))
        else $error("trigger stepped with advance source disabled");
    a_disable_restore: assert property ((r_reg.st == ssa_pkg::ST_RUN) && !r_reg.en
        |=> set_load && !set_active ##1 !set_active)
        else $error("disable did not restore the active set");
    a_drop_busy: assert property (trig_rise && !r_reg.wait_o |=> !acq_start)
        else $error("trigger accepted while not waiting");
    a_line_change_drop: assert property (trig_rise && (l1_if.busy || l2_if.busy) |=> !acq_start)
        else $error("trigger accepted while a line was changing");
    a_total_range: assert property ((r_reg.total >= 7'h01) && (r_reg.total <= ssa_pkg::TOTAL_MAX))
        else $error("set count out of range");
endmodule : ssa_ctrl

// >>> tb/ssa_src_model.sv
// trigger source and input line drivers facing the sequence set controller
`timescale 1ns/1ps
module ssa_src_model #(
    parameter int SETTLE_CYC = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // status from the device
    input wire logic trig_waiting,
    // pins toward the device
    output logic frame_trig,
    output logic line1,
    output logic line2
);
    // pins idle low until driven
    initial begin
        frame_trig = 1'b0;
        line1 = 1'b0;
        line2 = 1'b0;
    end

    // change both lines, then let the busy window run out when settle is set
    task automatic set_lines(input logic l1, input logic l2, input bit settle);
        @(posedge pclk);
        line1 <= l1;
        line2 <= l2;
        if (settle) begin
            repeat (SETTLE_CYC + 8) @(posedge pclk);
        end
    endtask : set_lines

    // one trigger pulse; a polite source waits for the waiting status
    task automatic fire(input bit rude);
        while (!rude && trig_waiting !== 1'b1) begin
            @(posedge pclk);
        end
        @(posedge pclk);
        frame_trig <= 1'b1;
        repeat (3) @(posedge pclk);
        frame_trig <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : fire
endmodule : ssa_src_model

// >>> tb/testbench.sv
// self-checking bench for the sequence set advance controller
`timescale 1ns/1ps
module testbench;
    logic pclk;
    logic presetn;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic frame_trig;
    logic line1;
    logic line2;
    logic [5:0] set_index;
    logic set_active;
    logic set_load;
    logic acq_start;
    logic [5:0] acq_set;
    logic trig_waiting;
    logic [31:0] last_acq;
    logic [31:0] n_acq;
    logic [31:0] n_load;
    int failures;
    int tests_run;

    // clock at 50 MHz
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    ssa_ctrl #(.SETTLE_CYC(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_trig(frame_trig), .line1(line1), .line2(line2), .set_index(set_index),
        .set_active(set_active), .set_load(set_load), .acq_start(acq_start), .acq_set(acq_set),
        .trig_waiting(trig_waiting)
    );

    ssa_src_model #(.SETTLE_CYC(4)) u_src (
        .pclk(pclk), .presetn(presetn), .trig_waiting(trig_waiting),
        .frame_trig(frame_trig), .line1(line1), .line2(line2)
    );

    // capture every accepted acquisition and every load of the active set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_acq <= 32'h0;
            n_acq <= 32'h0;
            n_load <= 32'h0;
        end else begin
            if (acq_start === 1'b1) begin
                last_acq <= {26'h0, acq_set};
                n_acq <= n_acq + 32'h1;
            end
            if (set_load === 1'b1) begin
                n_load <= n_load + 32'h1;
            end
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        check("write_err", {31'h0, err}, 32'h0);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        check("read_err", {31'h0, err}, {31'h0, exp_err});
        if (!exp_err) begin
            check("read_data", rd, exp);
        end
    endtask : rd_chk

    // polite trigger that must be accepted with the given set
    task automatic fire_chk(input logic [31:0] exp);
        logic [31:0] n0;
        n0 = n_acq;
        u_src.fire(1'b0);
        check("acq_count", n_acq, n0 + 32'h1);
        check("acq_set", last_acq, exp);
    endtask : fire_chk

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        summarize();
    end

    initial begin
        logic [31:0] n0;
        presetn = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        failures = 0;
        tests_run = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        // reset values and an unmapped place
        rd_chk(ssa_pkg::OFS_STATUS, 32'h00000200, 1'b0);
        rd_chk(ssa_pkg::OFS_TOTAL, 32'h00000040, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b1);
        // count limits at both ends
        wr(ssa_pkg::OFS_TOTAL, 32'h00000000);
        rd_chk(ssa_pkg::OFS_TOTAL, 32'h00000001, 1'b0);
        wr(ssa_pkg::OFS_TOTAL, 32'h00000064);
        rd_chk(ssa_pkg::OFS_TOTAL, 32'h00000040, 1'b0);
        wr(ssa_pkg::OFS_TOTAL, 32'h00000003);
        // enable with always-active source
        wr(ssa_pkg::OFS_CTRL, 32'h00000001);
        repeat (3) @(posedge pclk);
        check("set_index", {26'h0, set_index}, 32'h0);
        check("set_active", {31'h0, set_active}, 32'h1);
        check("load_count", n_load, 32'h1);
        fire_chk(32'h1);
        fire_chk(32'h2);
        fire_chk(32'h0);
        fire_chk(32'h1);
        // restart on line 1 beats the advance
        wr(ssa_pkg::OFS_CTRL, 32'h00000009);
        u_src.set_lines(1'b1, 1'b0, 1'b1);
        fire_chk(32'h0);
        u_src.set_lines(1'b0, 1'b0, 1'b1);
        // line 2 as advance source, plain and inverted
        wr(ssa_pkg::OFS_CTRL, 32'h00000005);
        fire_chk(32'h0);
        u_src.set_lines(1'b0, 1'b1, 1'b1);
        fire_chk(32'h1);
        wr(ssa_pkg::OFS_CTRL, 32'h00000045);
        fire_chk(32'h1);
        // source disabled: triggers alone do not step, the command does
        wr(ssa_pkg::OFS_CTRL, 32'h00000007);
        fire_chk(32'h1);
        wr(ssa_pkg::OFS_CMD, 32'h00000001);
        repeat (6) @(posedge pclk);
        check("set_index", {26'h0, set_index}, 32'h2);
        // trigger sent while a line is changing is dropped and counted
        n0 = n_acq;
        u_src.set_lines(1'b1, 1'b1, 1'b0);
        u_src.fire(1'b1);
        check("acq_count", n_acq, n0);
        repeat (12) @(posedge pclk);
        rd_chk(ssa_pkg::OFS_STATUS, 32'h00010702, 1'b0);
        // disabling clears the active flag with one load and keeps the set index
        n0 = n_load;
        wr(ssa_pkg::OFS_CTRL, 32'h00000000);
        repeat (3) @(posedge pclk);
        check("set_active", {31'h0, set_active}, 32'h0);
        check("set_index", {26'h0, set_index}, 32'h2);
        check("load_count", n_load, n0 + 32'h1);
        // fresh enable with line 1 advancing and line 2 restarting
        wr(ssa_pkg::OFS_CTRL, 32'h00000013);
        repeat (3) @(posedge pclk);
        check("set_index", {26'h0, set_index}, 32'h0);
        fire_chk(32'h0);
        u_src.set_lines(1'b1, 1'b0, 1'b1);
        fire_chk(32'h1);
        summarize();
    end
endmodule : testbench
